// ---- core/legacy_cfg_pkg.sv ----
// Shared constants, types and decode helpers for the legacy configuration front end
// ----------------------------------------------------------------------------
// Function
// R1: Present one indirect configuration access capability
// R2: Window write stores leading bytes into BAR
// R3: Window read fetches leading bytes from BAR
// R4: Driver keeps window offset size aligned
// R5: Driver uses window only inside described ranges
// R6: Legacy common header lives in BAR0
// R7: Any access width gives natural results
// R8: Header little endian, device area native
// R9: Header field order, widths and access
// R10: Vector fields follow header while MSI on
// R11: Device area at 24 or 20, moves
// R12: Device area immediately follows the headers
// R13: Upper feature bits read as unacknowledged
// R14: Zero byte to status 18 rejects
// R15: Transitional driver falls back to legacy
// R16: Non-transitional driver abandons legacy device
// R17: Driver programs BAR, size, offset first
// R18: Cause read clears it and interrupt
// R19: Window access matches direct header access
// ----------------------------------------------------------------------------
package legacy_cfg_pkg;
    // Legacy header byte offsets
    localparam logic [7:0] HDR_DEV_FEAT = 8'h00;
    localparam logic [7:0] HDR_DRV_FEAT = 8'h04;
    localparam logic [7:0] HDR_RING_ADDR = 8'h08;
    localparam logic [7:0] HDR_RING_DEPTH = 8'h0c;
    localparam logic [7:0] HDR_RING_SEL = 8'h0e;
    localparam logic [7:0] HDR_DOORBELL = 8'h10;
    localparam logic [7:0] HDR_STATUS = 8'h12;
    localparam logic [7:0] HDR_CAUSE = 8'h13;
    localparam logic [7:0] HDR_CFG_VEC = 8'h14;
    localparam logic [7:0] HDR_RING_VEC = 8'h16;
    localparam logic [7:0] DEVCFG_BASE_MSI = 8'h18;
    localparam logic [7:0] DEVCFG_BASE_PLAIN = 8'h14;
    localparam logic [7:0] DEVCFG_BYTES = 8'h40;
    localparam int HDR_BYTES = 24;
    localparam int DEVCFG_WORDS = 16;
    // Bytes software may write, and bytes that reset to all ones (unmapped vectors)
    localparam logic [23:0] HDR_WRITABLE = 24'hf7cff0;
    localparam logic [23:0] HDR_RESET_ONES = 24'hf00000;
    localparam int CAUSE_RING_BIT = 0;
    localparam int CAUSE_CFG_BIT = 1;
    // Indirect access capability in configuration space
    localparam logic [7:0] CAP_BASE = 8'h40;
    localparam logic [7:0] CAP_VNDR_ID = 8'h09;
    localparam logic [7:0] CAP_NEXT = 8'h00;
    localparam logic [7:0] CAP_LEN = 8'h14;
    localparam logic [7:0] CAP_TYPE_CFG = 8'h05;
    localparam logic [2:0] CAP_W_HDR = 3'h0;
    localparam logic [2:0] CAP_W_BAR = 3'h1;
    localparam logic [2:0] CAP_W_OFF = 3'h2;
    localparam logic [2:0] CAP_W_LEN = 3'h3;
    localparam logic [2:0] CAP_W_DATA = 3'h4;

    typedef struct packed {
        logic write;
        logic bar0;
        logic [2:0] size;
        logic [7:0] off;
        logic [31:0] wdata;
    } acc_req_s;

    typedef enum {ENG_IDLE, ENG_FETCH, ENG_DONE} eng_state_e;
    typedef enum {CW_IDLE, CW_ISSUE, CW_WAIT, CW_ACK} win_state_e;

    function automatic logic covers(input logic [7:0] off, input logic [2:0] size,
                                    input logic [7:0] b);
        covers = (b >= off) && ({1'b0, b} < ({1'b0, off} + {6'h00, size}));
    endfunction : covers

    function automatic logic [3:0] lane_mask(input logic [2:0] size);
        lane_mask = (size == 3'h1) ? 4'h1 : (size == 3'h2) ? 4'h3 : 4'hf;
    endfunction : lane_mask
endpackage : legacy_cfg_pkg

// ---- core/dev_cfg_mem.sv ----
// Byte-lane memory holding the device-specific configuration area
`timescale 1ns/1ps
module dev_cfg_mem
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Access
    input wire logic wr_en_in,
    input wire logic [3:0] addr_in,
    input wire logic [3:0] be_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);
    logic [31:0] mem_r [0:legacy_cfg_pkg::DEVCFG_WORDS-1];
    logic [31:0] rdata_r;

    // Bytes are stored as written, so any width reads back the same image
    // One process owns the array so no lane has a second driver
    always_ff @(posedge clock_in)
    begin
        for (int l = 0; l < 4; l++)
        begin
            if (wr_en_in && be_in[l])
                mem_r[addr_in][8*l +: 8] <= wdata_in[8*l +: 8];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            rdata_r <= 32'h0000_0000;
        else
            rdata_r <= mem_r[addr_in];
    end

    assign rdata_out = rdata_r;
endmodule : dev_cfg_mem

// ---- core/cfg_window_cap.sv ----
// Indirect BAR access capability registers in configuration space
`timescale 1ns/1ps
module cfg_window_cap
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Configuration space dword port
    input wire logic cfg_valid_in,
    input wire logic cfg_write_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_ack_out,
    // Request to the register engine
    output logic eng_valid_out,
    output legacy_cfg_pkg::acc_req_s eng_req_out,
    input wire logic eng_ready_in,
    input wire logic eng_done_in,
    input wire logic [31:0] eng_rdata_in
);
    legacy_cfg_pkg::win_state_e state_r;
    logic [7:0] bar_r;
    logic [31:0] off_r;
    logic [31:0] len_r;
    logic [31:0] data_r;
    logic [31:0] rdata_r;
    logic wr_r;

    wire logic [7:0] rel = cfg_addr_in - legacy_cfg_pkg::CAP_BASE;
    wire logic in_cap = (cfg_addr_in >= legacy_cfg_pkg::CAP_BASE) && (rel < 8'h14);
    wire logic [2:0] widx = in_cap ? rel[4:2] : 3'h7;
    wire logic take = (state_r == legacy_cfg_pkg::CW_IDLE) && cfg_valid_in;
    wire logic [31:0] bemask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}},
                                {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
    wire logic [31:0] wr_merge = (cfg_wdata_in & bemask);
    wire logic [3:0] lead = legacy_cfg_pkg::lane_mask(len_r[2:0]);
    wire logic [31:0] leadmask = {{8{lead[3]}}, {8{lead[2]}}, {8{lead[1]}}, {8{lead[0]}}};
    wire logic [31:0] cap_word =
        (widx == legacy_cfg_pkg::CAP_W_HDR) ? {legacy_cfg_pkg::CAP_TYPE_CFG,
            legacy_cfg_pkg::CAP_LEN, legacy_cfg_pkg::CAP_NEXT, legacy_cfg_pkg::CAP_VNDR_ID} :
        (widx == legacy_cfg_pkg::CAP_W_BAR) ? {24'h000000, bar_r} :
        (widx == legacy_cfg_pkg::CAP_W_OFF) ? off_r :
        (widx == legacy_cfg_pkg::CAP_W_LEN) ? len_r : 32'h0000_0000;

    // Only BAR0 is implemented; other BARs read zero and drop writes
    assign eng_valid_out = (state_r == legacy_cfg_pkg::CW_ISSUE);
    assign eng_req_out = '{write: wr_r, bar0: (bar_r == 8'h00) && (off_r[31:8] == 24'h0),
                           size: len_r[2:0], off: off_r[7:0], wdata: data_r};
    assign cfg_ack_out = (state_r == legacy_cfg_pkg::CW_ACK);
    assign cfg_rdata_out = rdata_r;

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            state_r <= legacy_cfg_pkg::CW_IDLE;
            bar_r <= 8'h00;
            off_r <= 32'h0000_0000;
            len_r <= 32'h0000_0000;
            data_r <= 32'h0000_0000;
            rdata_r <= 32'h0000_0000;
            wr_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                legacy_cfg_pkg::CW_IDLE:
                begin
                    if (take && widx == legacy_cfg_pkg::CAP_W_DATA)
                    begin
                        wr_r <= cfg_write_in;
                        if (cfg_write_in)
                            data_r <= (data_r & ~bemask) | wr_merge; // R2
                        state_r <= legacy_cfg_pkg::CW_ISSUE;
                    end
                    else if (take)
                    begin
                        if (cfg_write_in && widx == legacy_cfg_pkg::CAP_W_BAR && cfg_be_in[0])
                            bar_r <= cfg_wdata_in[7:0];
                        if (cfg_write_in && widx == legacy_cfg_pkg::CAP_W_OFF)
                            off_r <= (off_r & ~bemask) | wr_merge;
                        if (cfg_write_in && widx == legacy_cfg_pkg::CAP_W_LEN)
                            len_r <= (len_r & ~bemask) | wr_merge;
                        rdata_r <= cfg_write_in ? 32'h0000_0000 : cap_word; // R1
                        state_r <= legacy_cfg_pkg::CW_ACK;
                    end
                end
                legacy_cfg_pkg::CW_ISSUE:
                    if (eng_ready_in)
                        state_r <= legacy_cfg_pkg::CW_WAIT;
                legacy_cfg_pkg::CW_WAIT:
                    if (eng_done_in)
                    begin
                        if (!wr_r)
                            data_r <= (data_r & ~leadmask) | (eng_rdata_in & leadmask); // R3
                        rdata_r <= wr_r ? 32'h0000_0000
                                        : ((data_r & ~leadmask) | (eng_rdata_in & leadmask));
                        state_r <= legacy_cfg_pkg::CW_ACK;
                    end
                default:
                    state_r <= legacy_cfg_pkg::CW_IDLE;
            endcase
        end
    end
endmodule : cfg_window_cap

// ---- core/pci_legacy_config_access.sv ----
// Legacy I/O BAR0 register engine with indirect configuration window
`timescale 1ns/1ps
module pci_legacy_config_access
#(
    parameter logic [31:0] DEV_FEATURES = 32'h0000_0000
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // I/O BAR0 access port
    input wire logic io_valid_in,
    input wire logic io_write_in,
    input wire logic [2:0] io_size_in,
    input wire logic [7:0] io_addr_in,
    input wire logic [31:0] io_wdata_in,
    output logic io_ready_out,
    output logic io_ack_out,
    output logic [31:0] io_rdata_out,
    // Configuration space port
    input wire logic cfg_valid_in,
    input wire logic cfg_write_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_ack_out,
    // Device status and events
    input wire logic msix_enable_in,
    input wire logic non_transitional_in,
    input wire logic ring_event_in,
    input wire logic cfg_change_event_in,
    input wire logic [15:0] ring_depth_in,
    // Register outputs toward the device core
    output logic [63:0] driver_features_out,
    output logic [31:0] ring_base_page_out,
    output logic [15:0] ring_select_out,
    output logic [7:0] lifecycle_state_out,
    output logic [15:0] cfg_vector_out,
    output logic [15:0] ring_vector_out,
    output logic ring_doorbell_out,
    output logic [15:0] ring_doorbell_index_out,
    output logic intx_out,
    output logic rejected_out
);
    // ------------------------------------------------------------------------
    // Engine state
    // ------------------------------------------------------------------------
    legacy_cfg_pkg::eng_state_e state_r;
    legacy_cfg_pkg::eng_state_e state_nxt;
    legacy_cfg_pkg::acc_req_s req_r;
    legacy_cfg_pkg::acc_req_s win_req;
    logic src_win_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [7:0] hdr_r [0:legacy_cfg_pkg::HDR_BYTES-1];
    logic [7:0] img [0:legacy_cfg_pkg::HDR_BYTES-1];
    logic [7:0] cause_r;
    logic [7:0] cause_nxt;
    logic intx_r;
    logic reject_r;
    logic ntr_meta_r;
    logic ntr_sync_r;
    logic doorbell_r;
    logic win_valid;
    logic [31:0] mem_rdata;

    // ------------------------------------------------------------------------
    // Arbitration: direct I/O wins over the window
    // ------------------------------------------------------------------------
    wire logic idle = (state_r == legacy_cfg_pkg::ENG_IDLE);
    wire logic take_io = idle && io_valid_in;
    wire logic take_win = idle && !io_valid_in && win_valid;
    wire logic fetch = (state_r == legacy_cfg_pkg::ENG_FETCH);
    wire legacy_cfg_pkg::acc_req_s io_req = '{write: io_write_in, bar0: 1'b1,
                                              size: io_size_in, off: io_addr_in,
                                              wdata: io_wdata_in}; // R6

    assign io_ready_out = idle;
    assign io_ack_out = ack_r && !src_win_r;
    assign io_rdata_out = rdata_r;

    always_comb
    begin
        case (state_r)
            legacy_cfg_pkg::ENG_IDLE:
                state_nxt = (take_io || take_win) ? legacy_cfg_pkg::ENG_FETCH
                                                  : legacy_cfg_pkg::ENG_IDLE;
            legacy_cfg_pkg::ENG_FETCH:
                state_nxt = legacy_cfg_pkg::ENG_DONE;
            default:
                state_nxt = legacy_cfg_pkg::ENG_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Region decode; the device area moves with the MSI enable
    // ------------------------------------------------------------------------
    wire logic [7:0] dev_base = msix_enable_in ? legacy_cfg_pkg::DEVCFG_BASE_MSI
                                               : legacy_cfg_pkg::DEVCFG_BASE_PLAIN; // R11
    wire logic hdr_sel = req_r.bar0 && !reject_r;
    wire logic in_hdr = req_r.off < dev_base; // R10
    wire logic [7:0] dev_rel = req_r.off - dev_base; // R12
    wire logic in_dev = !in_hdr && (dev_rel < legacy_cfg_pkg::DEVCFG_BYTES);
    wire logic fetch_wr = fetch && req_r.write;
    wire logic [3:0] lanes = legacy_cfg_pkg::lane_mask(req_r.size);
    wire logic [31:0] keep = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    wire logic [4:0] shamt = {req_r.off[1:0], 3'h0};
    wire logic [31:0] wsh = (req_r.wdata & keep) << shamt;
    wire logic [3:0] mem_be = 4'(lanes << req_r.off[1:0]);
    wire logic mem_wr = fetch_wr && hdr_sel && in_dev; // R7

    dev_cfg_mem u_dev_cfg_mem
    (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .wr_en_in(mem_wr),
        .addr_in(dev_rel[5:2]),
        .be_in(mem_be),
        .wdata_in(wsh),
        .rdata_out(mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Legacy header bytes, little endian
    // ------------------------------------------------------------------------
    generate
        for (genvar b = 0; b < legacy_cfg_pkg::HDR_BYTES; b++)
        begin : g_hdr
            localparam logic [7:0] BI = 8'(b);
            localparam logic [7:0] RST = legacy_cfg_pkg::HDR_RESET_ONES[b] ? 8'hff : 8'h00;
            wire logic hit = legacy_cfg_pkg::covers(req_r.off, req_r.size, BI) && (BI < dev_base);
            if (b < 4)
            begin : g_feat
                assign img[b] = DEV_FEATURES[8*b +: 8]; // R9
            end
            else if (b == 12 || b == 13)
            begin : g_depth
                assign img[b] = ring_depth_in[8*(b-12) +: 8]; // R9
            end
            else if (b == 19)
            begin : g_cause
                assign img[b] = cause_r;
            end
            else
            begin : g_rw
                assign img[b] = hdr_r[b];
            end
            always_ff @(posedge clock_in)
            begin
                if (!rst_b_in)
                    hdr_r[b] <= RST;
                else if (fetch_wr && hdr_sel && hit && legacy_cfg_pkg::HDR_WRITABLE[b])
                    hdr_r[b] <= wsh[8*(b%4) +: 8]; // R9
            end
        end
    endgenerate

    wire logic [4:0] wbase = {req_r.off[4:2], 2'h0};
    wire logic [31:0] hdr_word = {img[wbase + 5'h3], img[wbase + 5'h2], // R8
                                  img[wbase + 5'h1], img[wbase]};
    wire logic [31:0] raw = !hdr_sel ? 32'h0000_0000 :
                            in_hdr ? hdr_word :
                            in_dev ? mem_rdata : 32'h0000_0000; // R14
    wire logic [31:0] rd_data = (raw >> shamt) & keep; // R3

    // ------------------------------------------------------------------------
    // Interrupt cause, read clears, new events win
    // ------------------------------------------------------------------------
    wire logic cause_rd = (state_r == legacy_cfg_pkg::ENG_DONE) && !req_r.write && hdr_sel && in_hdr &&
                          legacy_cfg_pkg::covers(req_r.off, req_r.size,
                                                 legacy_cfg_pkg::HDR_CAUSE);
    wire logic [7:0] cause_set = {6'h00, cfg_change_event_in, ring_event_in};
    wire logic reject_hit = fetch_wr && req_r.bar0 && ntr_sync_r && req_r.size == 3'h1 &&
                            req_r.off == legacy_cfg_pkg::HDR_STATUS &&
                            req_r.wdata[7:0] == 8'h00;
    wire logic bell_hit = fetch_wr && hdr_sel &&
        (legacy_cfg_pkg::covers(req_r.off, req_r.size, legacy_cfg_pkg::HDR_DOORBELL) ||
         legacy_cfg_pkg::covers(req_r.off, req_r.size, legacy_cfg_pkg::HDR_DOORBELL + 8'h01));

    // Clear at the data latch edge, so the read still returns the old cause
    assign cause_nxt = (cause_r & ~(cause_rd ? 8'hff : 8'h00)) | cause_set; // R18

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            state_r <= legacy_cfg_pkg::ENG_IDLE;
            req_r <= '0;
            src_win_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            cause_r <= 8'h00;
            intx_r <= 1'b0;
            reject_r <= 1'b0;
            ntr_meta_r <= 1'b0;
            ntr_sync_r <= 1'b0;
            doorbell_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (take_io || take_win)
            begin
                req_r <= take_io ? io_req : win_req; // R19
                src_win_r <= !take_io;
            end
            ack_r <= (state_r == legacy_cfg_pkg::ENG_DONE);
            if (state_r == legacy_cfg_pkg::ENG_DONE)
                rdata_r <= req_r.write ? 32'h0000_0000 : rd_data;
            cause_r <= cause_nxt; // R18
            intx_r <= (cause_nxt != 8'h00) && !msix_enable_in; // R18
            ntr_meta_r <= non_transitional_in;
            ntr_sync_r <= ntr_meta_r;
            if (reject_hit)
                reject_r <= 1'b1; // R14
            doorbell_r <= bell_hit;
        end
    end

    // ------------------------------------------------------------------------
    // Indirect window capability
    // ------------------------------------------------------------------------
    cfg_window_cap u_cfg_window_cap
    (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .cfg_valid_in(cfg_valid_in),
        .cfg_write_in(cfg_write_in),
        .cfg_addr_in(cfg_addr_in),
        .cfg_be_in(cfg_be_in),
        .cfg_wdata_in(cfg_wdata_in),
        .cfg_rdata_out(cfg_rdata_out),
        .cfg_ack_out(cfg_ack_out),
        .eng_valid_out(win_valid),
        .eng_req_out(win_req),
        .eng_ready_in(take_win),
        .eng_done_in(ack_r && src_win_r),
        .eng_rdata_in(rdata_r)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Upper features are never reachable here, so they stay unacknowledged
    assign driver_features_out = {32'h0000_0000, hdr_r[7], hdr_r[6], hdr_r[5], hdr_r[4]}; // R13
    assign ring_base_page_out = {hdr_r[11], hdr_r[10], hdr_r[9], hdr_r[8]};
    assign ring_select_out = {hdr_r[15], hdr_r[14]};
    assign lifecycle_state_out = hdr_r[18];
    assign cfg_vector_out = {hdr_r[21], hdr_r[20]};
    assign ring_vector_out = {hdr_r[23], hdr_r[22]};
    assign ring_doorbell_out = doorbell_r;
    assign ring_doorbell_index_out = {hdr_r[17], hdr_r[16]};
    assign intx_out = intx_r;
    assign rejected_out = reject_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_io_ack_time: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R19
        take_io |-> ##3 io_ack_out)
        else $error("direct access not answered in three cycles");

    a_win_done_time: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R2
        take_win |-> !io_ack_out ##3 (ack_r && src_win_r))
        else $error("window access not completed in three cycles");

    a_cause_read_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R18
        (cause_rd && !ring_event_in && !cfg_change_event_in) |=> (cause_r == 8'h00) && !intx_out)
        else $error("cause not cleared by read");

    a_cause_set_wins: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R18
        ring_event_in |=> cause_r[legacy_cfg_pkg::CAUSE_RING_BIT])
        else $error("ring event lost");

    a_reject_sticky_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R14
        reject_r |=> reject_r && (!ack_r || rdata_r == 32'h0000_0000))
        else $error("rejected device answered data");

    a_feat_write_low: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R13
        (take_io && io_write_in && io_size_in == 3'h4 && io_addr_in == 8'h04 && !reject_r)
        |-> ##2 driver_features_out == {32'h0000_0000, $past(io_wdata_in, 2)})
        else $error("driver features not stored");

    a_vec_after_hdr: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R10
        (take_io && !io_write_in && io_size_in == 3'h2 && io_addr_in == 8'h14 && !reject_r
         && msix_enable_in) ##1 msix_enable_in[*2]
        |-> ##1 io_rdata_out == {16'h0000, cfg_vector_out})
        else $error("vector field not after header");

    a_doorbell_pulse: assert property (@(posedge clock_in) disable iff (!rst_b_in) // R9
        bell_hit |=> ring_doorbell_out ##1 (!ring_doorbell_out || $past(bell_hit)))
        else $error("doorbell pulse wrong");
endmodule : pci_legacy_config_access

// ---- tb/host_io_model.sv ----
// Host driver model for I/O BAR0 requests
`timescale 1ns/1ps
module host_io_model
(
    // Clock
    input wire logic clock_in,
    // Request and answer
    output logic v_out,
    output logic w_out,
    output logic [2:0] sz_out,
    output logic [7:0] ad_out,
    output logic [31:0] wd_out,
    input wire logic rdy_in,
    input wire logic ack_in,
    input wire logic [31:0] rd_in
);
    initial {v_out, w_out, sz_out, ad_out, wd_out} = 44'h0;
    // Released address and data lines show inverted values so stale data cannot pass
    task automatic xfer(input logic w, input int s, input int a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(negedge clock_in);
        for (n = 0; rdy_in !== 1'b1 && n < 9; n++) @(negedge clock_in);
        {v_out, w_out, sz_out, ad_out, wd_out} = {1'b1, w, s[2:0], a[7:0], d};
        @(negedge clock_in);
        {v_out, ad_out, wd_out} = {1'b0, ~a[7:0], ~d};
        for (n = 0; ack_in !== 1'b1 && n < 9; n++) @(negedge clock_in);
        q = (ack_in === 1'b1) ? rd_in : 32'hxxxx_xxxx;
    endtask : xfer
endmodule : host_io_model

// ---- tb/pci_legacy_config_access_bench.sv ----
// Self-checking bench for the legacy configuration front end
`timescale 1ns/1ps
module pci_legacy_config_access_bench;
    localparam logic [31:0] FEAT = 32'h8e31_07a5;
    logic clock_in = 1'b0, rst_b_in = 1'b0, iv, iw, rdy, ack, cv = 1'b0, cw = 1'b0, ca;
    logic msi = 1'b0, ns = 1'b0, re = 1'b0, ce = 1'b0, intx, rej;
    logic [2:0] isz;
    logic [7:0] iad, cad = 8'h00, mdl [0:127];
    logic [15:0] depth = 16'h0, dbi;
    logic [31:0] iwd, ird, cwd = 32'h0, crd, q, rnd = 32'hfd1525de;
    logic [63:0] dfo;
    int fail_count = 0, samples_checked = 0;
    always #10 clock_in = ~clock_in;
    pci_legacy_config_access #(.DEV_FEATURES(FEAT)) dut_u (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .io_valid_in(iv), .io_write_in(iw), .io_size_in(isz),
        .io_addr_in(iad), .io_wdata_in(iwd), .io_ready_out(rdy), .io_ack_out(ack),
        .io_rdata_out(ird), .cfg_valid_in(cv), .cfg_write_in(cw), .cfg_addr_in(cad),
        .cfg_be_in(4'hf), .cfg_wdata_in(cwd), .cfg_rdata_out(crd), .cfg_ack_out(ca),
        .msix_enable_in(msi), .non_transitional_in(ns), .ring_event_in(re),
        .cfg_change_event_in(ce), .ring_depth_in(depth), .driver_features_out(dfo),
        .ring_base_page_out(), .ring_select_out(), .lifecycle_state_out(),
        .cfg_vector_out(), .ring_vector_out(), .ring_doorbell_out(),
        .ring_doorbell_index_out(dbi), .intx_out(intx), .rejected_out(rej));
    host_io_model host_u (.clock_in(clock_in), .v_out(iv), .w_out(iw), .sz_out(isz),
        .ad_out(iad), .wd_out(iwd), .rdy_in(rdy), .ack_in(ack), .rd_in(ird));
    // Device area bytes live at model index 64 and up, wherever the base sits
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int ix(input int a);
        ix = (a >= (msi ? 24 : 20)) ? 64 + a - (msi ? 24 : 20) : a;
    endfunction : ix
    function automatic logic [31:0] ex(input int a, input int s);
        ex = 32'h0;
        for (int b = 0; b < s; b++)
            ex[8*b +: 8] = (a + b < 4) ? FEAT[8*(a+b) +: 8] :
                (a + b inside {12, 13}) ? depth[8*(a+b-12) +: 8] : mdl[ix(a + b)];
    endfunction : ex
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic mw(input int a, input int s, input logic [31:0] d);
        for (int b = 0; b < s; b++)
            if (a + b >= 4 && !(a + b inside {12, 13, 19})) mdl[ix(a + b)] = d[8*b +: 8];
    endtask : mw
    task automatic io(input logic w, input int s, input int a, input logic [31:0] d);
        host_u.xfer(w, s, a, d, q);
        if (w) mw(a, s, d);
        else chk(q, ex(a, s));
    endtask : io
    task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(negedge clock_in);
        {cv, cw, cad, cwd} = {1'b1, w, a, d};
        for (n = 0; ca !== 1'b1 && n < 20; n++) @(negedge clock_in);
        {cv, q, cad, cwd} = {1'b0, crd, ~a, ~d};
    endtask : cfg
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        #400000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        for (int i = 0; i < 128; i++) mdl[i] = (i inside {20, 21, 22, 23}) ? 8'hff : 8'h00;
        repeat (5) @(negedge clock_in);
        {rst_b_in, msi} = 2'b11;
        io(1'b0, 4, 20, 32'h0);
        // Every header field, RO ones included, random values from the shift register
        for (int a = 0; a < 24; a += 2)
        begin
            rnd = lfsr(rnd);
            depth = rnd[31:16];
            io(1'b1, (a % 4 == 0) ? 4 : 2, a, rnd);
            io(1'b0, (a % 4 == 0) ? 4 : 2, a, 32'h0);
        end
        chk(dfo[63:32], 32'h0);
        chk(dfo[31:0], ex(4, 4));
        chk({16'h0, dbi}, ex(16, 2));
        msi = 1'b0;
        io(1'b1, 4, 20, rnd);
        for (int b = 0; b < 4; b++) io(1'b0, 1, 20 + b, 32'h0);
        msi = 1'b1;
        io(1'b0, 4, 24, 32'h0);
        io(1'b0, 4, 20, 32'h0);
        {msi, re, ce} = 3'b011;
        @(negedge clock_in);
        {re, ce} = 2'b00;
        repeat (2) @(negedge clock_in);
        chk(intx, 1'b1);
        mdl[19] = 8'h03;
        io(1'b0, 1, 19, 32'h0);
        mdl[19] = 8'h00;
        io(1'b0, 1, 19, 32'h0);
        chk(intx, 1'b0);
        cfg(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0514_0009);
        cfg(1'b1, 8'h44, 32'h0);
        cfg(1'b1, 8'h4c, 32'h4);
        cfg(1'b1, 8'h48, 32'h8);
        cfg(1'b1, 8'h50, ~rnd);
        mw(8, 4, ~rnd);
        io(1'b0, 4, 8, 32'h0);
        cfg(1'b0, 8'h50, 32'h0);
        chk(q, ex(8, 4));
        ns = 1'b1;
        repeat (3) @(negedge clock_in);
        io(1'b1, 1, 18, 32'h0);
        chk(rej, 1'b1);
        io(1'b1, 4, 8, rnd);
        mw(8, 4, 32'h0);
        io(1'b0, 4, 8, 32'h0);
        end_of_test();
    end
endmodule : pci_legacy_config_access_bench
